/* File: rtl/bag_regs.vh */
// Purpose: register offsets, field positions and constants of the blit address generators
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes: offsets are the low 24 bits of the register byte address
`ifndef BAG_REGS_VH
`define BAG_REGS_VH
`define BAG_OFF_PRI_CLIP 24'hF02208
`define BAG_OFF_PRI_PIXEL 24'hF0220C
`define BAG_OFF_PRI_STEP 24'hF02210
`define BAG_OFF_PRI_FSTEP 24'hF02214
`define BAG_OFF_PRI_FPIXEL 24'hF02218
`define BAG_OFF_PRI_INC 24'hF0221C
`define BAG_OFF_PRI_FINC 24'hF02220
`define BAG_OFF_PRI_FLAGS 24'hF0223C
`define BAG_OFF_SEC_BASE 24'hF02224
`define BAG_OFF_SEC_FLAGS 24'hF02228
`define BAG_OFF_SEC_MASK 24'hF0222C
`define BAG_OFF_SEC_PIXEL 24'hF02230
`define BAG_OFF_SEC_STEP 24'hF02234
`define BAG_OFF_CMD 24'hF02238
`define BAG_OFF_STATUS 24'hF02240
`define BAG_OFF_PASS 24'hF02244
`define BAG_PASS_INNER 2'h1
`define BAG_PASS_OUTER 2'h2
`define BAG_CMD_CLIP 6
`define BAG_CMD_UPD_PF 8
`define BAG_CMD_UPD_P 9
`define BAG_CMD_UPD_S 10
`define BAG_CMD_SWAP 11
`define BAG_FL_PSIZE_LO 3
`define BAG_FL_MASK 15
`define BAG_FL_XADD_LO 16
`define BAG_FL_YADD 18
`define BAG_FL_XSUB 19
`define BAG_FL_YSUB 20
`define BAG_XADD_PHRASE 2'h0
`define BAG_XADD_PIX 2'h1
`define BAG_XADD_ZERO 2'h2
`define BAG_XADD_INC 2'h3
`define BAG_PHRASE_BITS 7'h40
`define BAG_X_MAX 16'h7FFF
`define BAG_Y_MAX 16'h0FFF
`define BAG_PSIZE_MAX 3'h5
`endif

/* File: rtl/bag_blit_addr_gen.v */
// Purpose: register bank and pointer update logic of the two blit address generators
// Assumes: single clock core_clk at 200 MHz, Avalon-MM slave, engine supplies pass strobes
// Notes: data path, comparator and remaining command bits live outside this block
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps
`include "bag_regs.vh"

// Functional notes
// - clip size: 15-bit width low, 15-bit height high, top bits ignored.
// - with clipping on, block writes if pointer negative or at/after clip size.
// - off-phrase clip width clips right side even with clipping off.
// - pixel pointers hold signed 16-bit X low and Y high.
// - only X 0..32767 and Y 0..4095 give valid addresses.
// - step registers hold signed X and Y steps added between inner passes.
// - phrase mode leaves X at start of first unwritten phrase.
// - primary step fraction adds to pointer fraction between inner passes.
// - pointer fraction holds X fraction low, Y fraction high, with carry.
// - increment mode adds integer and fractional increment every inner pass.
// - secondary flags share primary layout for pitch, size, offset, width.
// - secondary flag bit 15 ANDs secondary pointer with window mask.
// - X mode 00 adds phrase and truncates, 01 pixel size, 10 zero.
// - bit 18 makes Y add zero or one per inner pass.
// - bit 19 with pixel mode subtracts pixel size; software avoids other modes.
// - bit 20 turns Y add one into subtract one.
// - any command write starts an operation; software writes it last.
// - pixel size is two to the n, n from 0 to 5.
// - primary Y add bit governs both generators; sign needs add bit.
// - command swap bit makes secondary destination and primary source.
// - command clip bit inhibits out-of-window writes; operation continues.
module bag_blit_addr_gen (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // avalon-mm slave
   input wire [23:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   // engine side
   input wire [1:0] pass_strobe,
   output reg start_pulse,
   output reg [31:0] command,
   output reg dest_write_enable,
   output reg swap_generator_roles,
   output reg [31:0] primary_address,
   output reg primary_address_valid,
   output reg [31:0] secondary_address,
   output reg secondary_address_valid
);

   reg [31:0] primary_clip_size;
   reg [31:0] primary_pixel_pointer;
   reg [31:0] primary_step;
   reg [31:0] primary_step_fraction;
   reg [31:0] primary_pointer_fraction;
   reg [31:0] primary_increment;
   reg [31:0] primary_increment_fraction;
   reg [31:0] primary_flags;
   reg [31:0] secondary_window_base;
   reg [31:0] secondary_flags;
   reg [31:0] secondary_window_mask;
   reg [31:0] secondary_pixel_pointer;
   reg [31:0] secondary_step;
   reg busy;
   reg acked;

   wire primary_clip_enable = command[`BAG_CMD_CLIP];
   // a write lands only on the edge that answers it
   wire hit_write = avs_write & ~avs_waitrequest;

   // byte-lane merge
   function [31:0] merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0] be;
      integer i;
      begin
         merge = old_val;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i])
               merge[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
   endfunction

   // per-pass X delta in pixels for one generator's flags
   function [15:0] x_delta;
      input [31:0] flags;
      input [15:0] inc_x;
      reg [2:0] psize;
      reg [6:0] ppp;
      begin
         psize = flags[`BAG_FL_PSIZE_LO +: 3];
         if (psize > `BAG_PSIZE_MAX)
            psize = `BAG_PSIZE_MAX;
         ppp = `BAG_PHRASE_BITS >> psize;
         case (flags[`BAG_FL_XADD_LO +: 2])
            `BAG_XADD_PHRASE: x_delta = {9'h000, ppp};
            `BAG_XADD_PIX: x_delta = flags[`BAG_FL_XSUB] ? 16'hFFFF : 16'h0001;
            `BAG_XADD_ZERO: x_delta = 16'h0000;
            default: x_delta = inc_x;
         endcase
      end
   endfunction

   // phrase truncation mask for X
   function [15:0] phrase_mask;
      input [31:0] flags;
      reg [2:0] psize;
      reg [6:0] ppp;
      begin
         psize = flags[`BAG_FL_PSIZE_LO +: 3];
         if (psize > `BAG_PSIZE_MAX)
            psize = `BAG_PSIZE_MAX;
         ppp = `BAG_PHRASE_BITS >> psize;
         if (flags[`BAG_FL_XADD_LO +: 2] == `BAG_XADD_PHRASE)
            phrase_mask = ~({9'h000, ppp} - 16'h0001);
         else
            phrase_mask = 16'hFFFF;
      end
   endfunction

   // y delta: primary Y add bit governs both, sign needs add bit
   function [15:0] y_delta;
      input [31:0] flags;
      input yadd;
      begin
         if (!yadd)
            y_delta = 16'h0000;
         else if (flags[`BAG_FL_YSUB])
            y_delta = 16'hFFFF;
         else
            y_delta = 16'h0001;
      end
   endfunction

   // valid address range
   function in_range;
      input [31:0] ptr;
      begin
         in_range = ~ptr[15] & ~ptr[31] & (ptr[31:16] <= `BAG_Y_MAX);
      end
   endfunction

   // clip test and address forming
   reg [31:0] next_pri_ptr;
   reg [31:0] next_pri_frac;
   reg [31:0] next_sec_ptr;
   reg [31:0] sec_masked;
   reg [15:0] clip_w;
   reg [15:0] clip_h;
   reg [15:0] pri_x_mask;
   reg [16:0] fsum_x;
   reg [16:0] fsum_y;
   reg [15:0] carry_x;
   reg [15:0] carry_y;
   reg out_of_window;
   reg phrase_clip;
   reg next_dest_we;
   reg [2:0] pri_ps;

   always @* begin
      clip_w = {1'b0, primary_clip_size[14:0]};
      clip_h = {1'b0, primary_clip_size[30:16]};
      pri_ps = primary_flags[`BAG_FL_PSIZE_LO +: 3];
      if (pri_ps > `BAG_PSIZE_MAX)
         pri_ps = `BAG_PSIZE_MAX;
      pri_x_mask = ({9'h000, `BAG_PHRASE_BITS >> pri_ps}) - 16'h0001;
      out_of_window = primary_pixel_pointer[15] | primary_pixel_pointer[31]
         | (primary_pixel_pointer[15:0] >= clip_w)
         | (primary_pixel_pointer[31:16] >= clip_h);
      // off-phrase clip width clips the right edge regardless
      phrase_clip = ((clip_w & pri_x_mask) != 16'h0000)
         & (primary_pixel_pointer[15:0] >= (clip_w & ~pri_x_mask));
      next_dest_we = busy & ~((primary_clip_enable & out_of_window) | phrase_clip);
      sec_masked = secondary_flags[`BAG_FL_MASK]
         ? (secondary_pixel_pointer & secondary_window_mask)
         : secondary_pixel_pointer;

      next_pri_ptr = primary_pixel_pointer;
      next_pri_frac = primary_pointer_fraction;
      next_sec_ptr = sec_masked;
      fsum_x = 17'h00000;
      fsum_y = 17'h00000;
      carry_x = 16'h0000;
      carry_y = 16'h0000;
      if (busy && pass_strobe == `BAG_PASS_INNER) begin
         if (primary_flags[`BAG_FL_XADD_LO +: 2] == `BAG_XADD_INC) begin
            // fraction carry feeds the integer add of the same pass
            fsum_x = {1'b0, primary_pointer_fraction[15:0]}
               + {1'b0, primary_increment_fraction[15:0]};
            fsum_y = {1'b0, primary_pointer_fraction[31:16]}
               + {1'b0, primary_increment_fraction[31:16]};
            carry_x = {15'h0000, fsum_x[16]};
            carry_y = {15'h0000, fsum_y[16]};
            next_pri_frac = {fsum_y[15:0], fsum_x[15:0]};
            next_pri_ptr[15:0] = primary_pixel_pointer[15:0] + primary_increment[15:0]
               + carry_x;
            next_pri_ptr[31:16] = primary_pixel_pointer[31:16] + primary_increment[31:16]
               + carry_y;
         end else begin
            next_pri_ptr[15:0] = (primary_pixel_pointer[15:0]
               + x_delta(primary_flags, primary_increment[15:0])) & phrase_mask(primary_flags);
            next_pri_ptr[31:16] = primary_pixel_pointer[31:16]
               + y_delta(primary_flags, primary_flags[`BAG_FL_YADD]);
         end
         next_sec_ptr[15:0] = (sec_masked[15:0]
            + x_delta(secondary_flags, 16'h0000)) & phrase_mask(secondary_flags);
         next_sec_ptr[31:16] = sec_masked[31:16]
            + y_delta(secondary_flags, primary_flags[`BAG_FL_YADD]);
      end else if (busy && pass_strobe == `BAG_PASS_OUTER) begin
         if (command[`BAG_CMD_UPD_PF]) begin
            fsum_x = {1'b0, primary_pointer_fraction[15:0]}
               + {1'b0, primary_step_fraction[15:0]};
            fsum_y = {1'b0, primary_pointer_fraction[31:16]}
               + {1'b0, primary_step_fraction[31:16]};
            next_pri_frac = {fsum_y[15:0], fsum_x[15:0]};
         end
         if (command[`BAG_CMD_UPD_P]) begin
            next_pri_ptr[15:0] = primary_pixel_pointer[15:0] + primary_step[15:0]
               + {15'h0000, fsum_x[16]};
            next_pri_ptr[31:16] = primary_pixel_pointer[31:16] + primary_step[31:16]
               + {15'h0000, fsum_y[16]};
         end
         if (command[`BAG_CMD_UPD_S]) begin
            next_sec_ptr[15:0] = sec_masked[15:0] + secondary_step[15:0];
            next_sec_ptr[31:16] = sec_masked[31:16] + secondary_step[31:16];
         end
      end
   end

   // avalon slave: one wait cycle, then answer
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
         acked <= 1'b0;
      end else begin
         if (acked) begin
            avs_waitrequest <= 1'b1;
            acked <= 1'b0;
         end else if (avs_read | avs_write) begin
            avs_waitrequest <= 1'b0;
            acked <= 1'b1;
            case (avs_address)
               `BAG_OFF_PRI_PIXEL: avs_readdata <= primary_pixel_pointer;
               `BAG_OFF_PRI_FPIXEL: avs_readdata <= primary_pointer_fraction;
               `BAG_OFF_SEC_PIXEL: avs_readdata <= secondary_pixel_pointer;
               `BAG_OFF_STATUS: avs_readdata <= {30'h00000000, dest_write_enable, busy};
               default: avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end

   // register file and pointer state
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         primary_clip_size <= 32'h00000000;
         primary_pixel_pointer <= 32'h00000000;
         primary_step <= 32'h00000000;
         primary_step_fraction <= 32'h00000000;
         primary_pointer_fraction <= 32'h00000000;
         primary_increment <= 32'h00000000;
         primary_increment_fraction <= 32'h00000000;
         primary_flags <= 32'h00000000;
         secondary_window_base <= 32'h00000000;
         secondary_flags <= 32'h00000000;
         secondary_window_mask <= 32'h00000000;
         secondary_pixel_pointer <= 32'h00000000;
         secondary_step <= 32'h00000000;
         command <= 32'h00000000;
         busy <= 1'b0;
         start_pulse <= 1'b0;
      end else begin
         start_pulse <= 1'b0;
         primary_pixel_pointer <= next_pri_ptr;
         primary_pointer_fraction <= next_pri_frac;
         secondary_pixel_pointer <= next_sec_ptr;
         if (busy && pass_strobe == (`BAG_PASS_INNER | `BAG_PASS_OUTER))
            busy <= 1'b0;
         // software write comes after the pass update, so it wins
         if (hit_write) begin
            case (avs_address)
               `BAG_OFF_PRI_CLIP: begin
                  primary_clip_size <=
                     merge(primary_clip_size, avs_writedata, avs_byteenable);
               end
               `BAG_OFF_PRI_PIXEL: begin
                  primary_pixel_pointer <=
                     merge(primary_pixel_pointer, avs_writedata, avs_byteenable);
               end
               `BAG_OFF_PRI_STEP: begin
                  primary_step <=
                     merge(primary_step, avs_writedata, avs_byteenable);
               end
               `BAG_OFF_PRI_FSTEP: begin
                  primary_step_fraction <=
                     merge(primary_step_fraction, avs_writedata, avs_byteenable);
               end
               `BAG_OFF_PRI_FPIXEL: begin
                  primary_pointer_fraction <=
                     merge(primary_pointer_fraction, avs_writedata, avs_byteenable);
               end
               `BAG_OFF_PRI_INC: begin
                  primary_increment <=
                     merge(primary_increment, avs_writedata, avs_byteenable);
               end
               `BAG_OFF_PRI_FINC: begin
                  primary_increment_fraction <=
                     merge(primary_increment_fraction, avs_writedata, avs_byteenable);
               end
               `BAG_OFF_PRI_FLAGS: begin
                  primary_flags <=
                     merge(primary_flags, avs_writedata, avs_byteenable);
               end
               `BAG_OFF_SEC_BASE: begin
                  secondary_window_base <=
                     merge(secondary_window_base, avs_writedata, avs_byteenable);
               end
               `BAG_OFF_SEC_FLAGS: begin
                  secondary_flags <=
                     merge(secondary_flags, avs_writedata, avs_byteenable);
               end
               `BAG_OFF_SEC_MASK: begin
                  secondary_window_mask <=
                     merge(secondary_window_mask, avs_writedata, avs_byteenable);
               end
               `BAG_OFF_SEC_PIXEL: begin
                  secondary_pixel_pointer <=
                     merge(secondary_pixel_pointer, avs_writedata, avs_byteenable);
               end
               `BAG_OFF_SEC_STEP: begin
                  secondary_step <=
                     merge(secondary_step, avs_writedata, avs_byteenable);
               end
               `BAG_OFF_CMD: begin
                  command <= merge(command, avs_writedata, avs_byteenable);
                  busy <= 1'b1;
                  start_pulse <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   // engine-facing outputs
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dest_write_enable <= 1'b0;
         swap_generator_roles <= 1'b0;
         primary_address <= 32'h00000000;
         primary_address_valid <= 1'b0;
         secondary_address <= 32'h00000000;
         secondary_address_valid <= 1'b0;
      end else begin
         dest_write_enable <= next_dest_we;
         swap_generator_roles <= command[`BAG_CMD_SWAP];
         primary_address <= primary_pixel_pointer;
         primary_address_valid <= in_range(primary_pixel_pointer);
         secondary_address <= sec_masked;
         secondary_address_valid <= in_range(sec_masked);
      end
   end

endmodule

/* File: tb/bag_blit_addr_gen_assertions.sv */
// Purpose: concurrent checks on the address generator ports
// Assumes: one clock domain, rst asynchronous and active high
// Notes: attached to every design instance by the bind below
`timescale 1ns/100ps
`include "bag_regs.vh"
module bag_chk (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // register bus
   input wire [23:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   // engine side
   input wire [1:0] pass_strobe,
   input wire start_pulse,
   input wire [31:0] command,
   input wire dest_write_enable,
   input wire swap_generator_roles,
   input wire [31:0] primary_address,
   input wire primary_address_valid
);
   wire cmd_wr = avs_write && avs_address == `BAG_OFF_CMD;
   reg [1:0] age;
   // outputs need a few cycles after reset before relations hold
   always @(posedge core_clk or posedge rst) begin
      if (rst)
         age <= 2'h0;
      else if (age != 2'h3)
         age <= age + 2'h1;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   chk_bus_reply: assert property ((avs_read || avs_write) && avs_waitrequest
      |-> ##[1:2] !avs_waitrequest) else $error("bus request left unanswered");
   chk_reply_once: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_wo_zero: assert property (avs_read && !avs_waitrequest
      && (avs_address == `BAG_OFF_PRI_CLIP || avs_address == `BAG_OFF_PASS)
      |-> avs_readdata == 32'h0) else $error("write-only or unmapped read not zero");
   chk_start_cmd: assert property (cmd_wr && !avs_waitrequest |-> ##[0:2] start_pulse)
      else $error("command write did not start an operation");
   chk_start_cause: assert property ($rose(start_pulse) |-> $past(cmd_wr))
      else $error("start without a command write");
   chk_start_single: assert property (start_pulse |=> !start_pulse)
      else $error("start pulse longer than one cycle");
   chk_swap_bit: assert property ($stable(command) |-> swap_generator_roles == command[11])
      else $error("role swap differs from command bit");
   chk_prim_valid: assert property (age == 2'h3 && $stable(primary_address)
      |-> primary_address_valid == (!primary_address[15] && primary_address[31:16] <= 16'h0FFF))
      else $error("primary valid flag wrong");
   chk_end_idle: assert property (pass_strobe == 2'h3 && !avs_write
      |-> ##3 !dest_write_enable) else $error("writes enabled after operation end");
   chk_clip_neg: assert property (age == 2'h3 && command[6] && $stable(command)
      && $stable(primary_address) && (primary_address[15] || primary_address[31])
      |-> !dest_write_enable) else $error("negative pointer not clipped");
endmodule
bind bag_blit_addr_gen bag_chk u_chk (.core_clk(core_clk), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .pass_strobe(pass_strobe), .start_pulse(start_pulse), .command(command),
   .dest_write_enable(dest_write_enable), .swap_generator_roles(swap_generator_roles),
   .primary_address(primary_address), .primary_address_valid(primary_address_valid));

/* File: tb/tb_bag_blit_addr_gen.sv */
// Purpose: self-checking bench for the blit address generators
// Assumes: 200 MHz clock, reset held for 5 cycles
// Notes: random values come from a fixed seed
`timescale 1ns/100ps
`include "bag_regs.vh"
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin errors++; \
   $display("wrong value at %0t: %s", $time, m); end end
module tb_bag_blit_addr_gen;
   reg core_clk, rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0, sb, pa, sa, ys;
   reg [23:0] avs_address = 24'h0;
   reg [31:0] avs_writedata = 32'h0, q, p, s, r, t;
   reg [3:0] avs_byteenable = 4'hF;
   reg [1:0] pass_strobe = 2'h0, m;
   reg [2:0] n;
   reg [15:0] ye;
   wire [31:0] avs_readdata, command, primary_address, secondary_address;
   wire avs_waitrequest, start_pulse, dest_write_enable, swap_generator_roles;
   wire primary_address_valid, secondary_address_valid;
   int errors = 0, samples_checked = 0, starts = 0, i, st;
   bag_blit_addr_gen dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pass_strobe(pass_strobe),
      .start_pulse(start_pulse), .command(command), .dest_write_enable(dest_write_enable),
      .swap_generator_roles(swap_generator_roles), .primary_address(primary_address),
      .primary_address_valid(primary_address_valid), .secondary_address(secondary_address),
      .secondary_address_valid(secondary_address_valid));
   initial begin
      core_clk = 1'h0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (start_pulse === 1'h1)
         starts++;
   end
   task report_and_stop;
      $display("comparisons %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one register access; held until waitrequest is seen low
   task bus(input logic w, input [23:0] a, input [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do
         @(posedge core_clk);
      while (avs_waitrequest !== 1'h0);
      q = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask
   // one engine pass strobe, then let outputs settle
   task strobe(input [1:0] v);
      @(posedge core_clk);
      pass_strobe <= v;
      @(posedge core_clk);
      pass_strobe <= 2'h0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task clip(input logic en, input logic sw, input [31:0] sz, input [31:0] pt, input logic e);
      bus(1'h1, `BAG_OFF_PRI_CLIP, sz);
      bus(1'h1, `BAG_OFF_PRI_PIXEL, pt);
      bus(1'h1, `BAG_OFF_CMD, {20'h0, sw, 4'h0, en, 6'h0});
      strobe(2'h0);
      `CHK(dest_write_enable, e, "destination write enable")
      `CHK(swap_generator_roles, sw, "role swap")
      `CHK(command, {20'h0, sw, 4'h0, en, 6'h0}, "command word")
      strobe(2'h3);
   endtask
   function [15:0] xn(input [1:0] md, input sub, input [2:0] ps, input [15:0] x);
      reg [15:0] w;
      w = 16'h40 >> ps;
      case (md)
         2'h0: xn = (x + w) & ~(w - 16'h1);
         2'h1: xn = sub ? x - 16'h1 : x + 16'h1;
         default: xn = x;
      endcase
   endfunction
   initial begin
      void'($urandom(32'h0355));
      repeat (5) @(posedge core_clk);
      rst <= 1'h0;
      for (i = 0; i < 6; i++) begin
         p = (i == 0) ? 32'h0FFF7FFF : (i == 1) ? 32'h10000000 : $urandom;
         s = $urandom;
         bus(1'h1, `BAG_OFF_PRI_PIXEL, p);
         bus(1'h1, `BAG_OFF_SEC_PIXEL, s);
         bus(1'h1, `BAG_OFF_PRI_FPIXEL, s);
         strobe(2'h0);
         `CHK(primary_address, p, "primary pointer")
         `CHK(secondary_address, s, "secondary pointer")
         `CHK(primary_address_valid, !p[15] && p[31:16] <= 16'h0FFF, "valid")
         `CHK(secondary_address_valid, !s[15] && s[31:16] <= 16'h0FFF, "valid 2")
         bus(1'h0, `BAG_OFF_PRI_FPIXEL, 32'h0);
         `CHK(q, s, "fraction readback")
      end
      bus(1'h0, `BAG_OFF_PRI_CLIP, 32'h0);
      `CHK(q, 32'h0, "write-only read")
      bus(1'h0, `BAG_OFF_PASS, 32'h0);
      `CHK(q, 32'h0, "unmapped read")
      $display("test registers done");
      for (i = 0; i < 12; i++) begin
         m = 2'(i % 3);
         sb = (m == 2'h1) && $urandom % 2;
         n = 3'($urandom % 6);
         {pa, sa, ys} = 3'($urandom);
         ys = ys & pa & sa;
         s = ($urandom & 32'h07FE3FFF) | 32'h00010000;
         bus(1'h1, `BAG_OFF_SEC_FLAGS, {11'h0, ys, sb, sa, m, 10'h0, n, 3'h0});
         bus(1'h1, `BAG_OFF_PRI_FLAGS, {11'h0, ys, 1'h0, pa, 2'h2, 16'h0});
         bus(1'h1, `BAG_OFF_SEC_PIXEL, s);
         st = starts;
         bus(1'h1, `BAG_OFF_CMD, 32'h0);
         strobe(2'h1);
         ye = pa ? (ys ? s[31:16] - 16'h1 : s[31:16] + 16'h1) : s[31:16];
         `CHK(secondary_address, {ye, xn(m, sb, n, s[15:0])}, "x/y update")
         `CHK(starts, st + 1, "start count")
         strobe(2'h3);
      end
      r = $urandom;
      s = $urandom;
      bus(1'h1, `BAG_OFF_SEC_FLAGS, 32'h00028000);
      bus(1'h1, `BAG_OFF_SEC_MASK, r);
      bus(1'h1, `BAG_OFF_SEC_PIXEL, s);
      strobe(2'h0);
      `CHK(secondary_address, s & r, "masked pointer")
      $display("test secondary update done");
      r = $urandom & 32'h003F003F;
      t = $urandom & 32'h003F003F;
      bus(1'h1, `BAG_OFF_PRI_FLAGS, 32'h00030000);
      bus(1'h1, `BAG_OFF_SEC_FLAGS, 32'h00020000);
      bus(1'h1, `BAG_OFF_PRI_INC, r);
      bus(1'h1, `BAG_OFF_PRI_FINC, 32'h00008000);
      bus(1'h1, `BAG_OFF_PRI_FPIXEL, 32'h80008000);
      bus(1'h1, `BAG_OFF_PRI_STEP, t);
      bus(1'h1, `BAG_OFF_PRI_FSTEP, 32'h80000000);
      bus(1'h1, `BAG_OFF_SEC_STEP, t);
      bus(1'h1, `BAG_OFF_PRI_PIXEL, 32'h00400400);
      bus(1'h1, `BAG_OFF_SEC_PIXEL, 32'h00200200);
      bus(1'h1, `BAG_OFF_CMD, 32'h00000700);
      strobe(2'h1);
      p = {16'h0040 + r[31:16], 16'h0401 + r[15:0]};
      `CHK(primary_address, p, "increment pass")
      strobe(2'h2);
      `CHK(primary_address, {p[31:16] + t[31:16] + 16'h1, p[15:0] + t[15:0]}, "outer step")
      `CHK(secondary_address, {16'h0020 + t[31:16], 16'h0200 + t[15:0]}, "secondary step")
      bus(1'h0, `BAG_OFF_PRI_FPIXEL, 32'h0);
      `CHK(q, 32'h0, "fraction after carry")
      strobe(2'h3);
      $display("test increment and step done");
      bus(1'h1, `BAG_OFF_SEC_BASE, $urandom & 32'hFFFFFFF8);
      bus(1'h1, `BAG_OFF_PRI_FLAGS, 32'h00020020);
      clip(1'h1, 1'h0, 32'h80108010, 32'h000F000F, 1'h1);
      clip(1'h1, 1'h0, 32'h80108010, 32'h00000010, 1'h0);
      clip(1'h1, 1'h0, 32'h80108010, 32'h00100000, 1'h0);
      clip(1'h1, 1'h0, 32'h80108010, 32'h0000FFFF, 1'h0);
      clip(1'h1, 1'h0, 32'h00100010, 32'hFFFF0000, 1'h0);
      clip(1'h0, 1'h0, 32'h0010000A, 32'h00000009, 1'h0);
      clip(1'h0, 1'h0, 32'h0010000A, 32'h00000007, 1'h1);
      clip(1'h0, 1'h1, 32'h00000000, 32'h00000064, 1'h1);
      $display("test clipping done");
      report_and_stop;
   end
   initial begin
      #50000;
      errors++;
      report_and_stop;
   end
endmodule
